// [inc/acc_defines.vh]
`ifndef ACC_DEFINES_VH
`define ACC_DEFINES_VH
`define ACC_ADDR_RESULT   8'h84
`define ACC_ADDR_CONTROL  8'hA0
`define ACC_BIT_ENABLE    5
`define ACC_BIT_DONE      4
`define ACC_BIT_START     3
`define ACC_CONV_MCYCLES  6'd40
`define ACC_CLK_PER_MC    4'd12
`define ACC_NUM_CH        5
`define ACC_CTRL_RESET    8'h00
`endif

// [hw/acc_mc_tick.v]
`timescale 1ns/1ns
`include "acc_defines.vh"
// Machine-cycle tick: one pulse every twelve core clocks
module acc_mc_tick (
  // Clock and reset
  input  wire i_ref_clk,
  input  wire i_srst,
  // Restart and tick
  input  wire i_restart,
  output reg  o_tick
);
  reg [3:0] cnt;
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      cnt    <= 4'h0;
      o_tick <= 1'b0;
    end else if (i_restart) begin
      // The start edge is the first core clock, so a run is exactly 480
      cnt    <= 4'h1;
      o_tick <= 1'b0;
    end else if (cnt == `ACC_CLK_PER_MC - 4'd1) begin
      cnt    <= 4'h0;
      o_tick <= 1'b1;
    end else begin
      cnt    <= cnt + 4'd1;
      o_tick <= 1'b0;
    end
  end
endmodule // acc_mc_tick

// [hw/acc_pin_mux.v]
`timescale 1ns/1ns
`include "acc_defines.vh"
// Digital view of the shared analog pins
module acc_pin_mux #(
  parameter NCH = `ACC_NUM_CH
) (
  // Clock and reset
  input  wire           i_ref_clk,
  input  wire           i_srst,
  // Control
  input  wire           i_enable,
  input  wire [2:0]     i_chan,
  // Pins
  input  wire [NCH-1:0] i_pin_in,
  input  wire [NCH-1:0] i_port_out,
  input  wire [NCH-1:0] i_port_oe,
  output reg  [NCH-1:0] o_pin_out,
  output reg  [NCH-1:0] o_pin_oe,
  output reg  [NCH-1:0] o_port_rd
);
  integer k;
  reg [NCH-1:0] next_rd;
  reg [NCH-1:0] next_oe;
  always @* begin
    next_rd = i_pin_in;
    next_oe = i_port_oe;
    for (k = 0; k < NCH; k = k + 1) begin
      if (i_enable) begin
        // Drivers float while enabled; software must not drive them
        next_oe[k] = 1'b0;
        if (i_chan == k[2:0])
          next_rd[k] = 1'b1;
      end
    end
  end
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_pin_out <= {NCH{1'b0}};
      o_pin_oe  <= {NCH{1'b0}};
      o_port_rd <= {NCH{1'b1}};
    end else begin
      o_pin_out <= i_port_out;
      o_pin_oe  <= next_oe;
      o_port_rd <= next_rd;
    end
  end
endmodule // acc_pin_mux

// [hw/acc_top.v]
`timescale 1ns/1ns
`include "acc_defines.vh"
module acc_top #(
  parameter NCH = `ACC_NUM_CH
) (
  // Clock and reset
  input  wire           i_ref_clk,
  input  wire           i_srst,
  // Special function register access, byte wide
  input  wire [7:0]     i_sfr_addr,
  input  wire           i_sfr_wr,
  input  wire           i_sfr_rd,
  input  wire [7:0]     i_sfr_wdata,
  output reg  [7:0]     o_sfr_rdata,
  // Power modes and interrupt enable
  input  wire           i_idle_enter,
  input  wire           i_pdown_enter,
  input  wire           i_converter_interrupt_enable,
  output reg            o_irq,
  // Analog front end
  input  wire [7:0]     i_analog_sample,
  output reg  [2:0]     o_mux_sel,
  output reg            o_conv_active,
  // Shared pins
  input  wire [NCH-1:0] i_pin_in,
  input  wire [NCH-1:0] i_port_out,
  input  wire [NCH-1:0] i_port_oe,
  output wire [NCH-1:0] o_pin_out,
  output wire [NCH-1:0] o_pin_oe,
  output wire [NCH-1:0] o_port_rd
);
  // ---------------------------------------------------------------
  // Control state
  // ---------------------------------------------------------------
  reg       converter_enable;
  reg       conversion_done_flag;
  reg       conversion_start_busy;
  reg [2:0] channel_select_field;
  reg [7:0] conversion_result;
  reg [5:0] mc_count;
  wire      mc_tick;

  wire wr_ctrl = i_sfr_wr && (i_sfr_addr == `ACC_ADDR_CONTROL);
  wire rd_res  = i_sfr_rd && (i_sfr_addr == `ACC_ADDR_RESULT);
  // Abort only hits a running conversion; a finished one is kept
  wire abort   = (i_idle_enter || i_pdown_enter) && conversion_start_busy;
  wire start   = wr_ctrl && i_sfr_wdata[`ACC_BIT_START]
                 && !conversion_start_busy && !conversion_done_flag;
  wire finish  = conversion_start_busy && mc_tick && !abort
                 && (mc_count == `ACC_CONV_MCYCLES - 6'd1);

  acc_mc_tick u_tick (
    .i_ref_clk (i_ref_clk),
    .i_srst    (i_srst),
    .i_restart (start),
    .o_tick    (mc_tick)
  );

  // ---------------------------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------------------------
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      converter_enable      <= 1'b0;
      conversion_done_flag  <= 1'b0;
      conversion_start_busy <= 1'b0;
      channel_select_field  <= 3'h0;
      conversion_result     <= 8'h00;
      mc_count              <= 6'h00;
    end else begin
      // Whole-byte write only; bits 7:6 are dropped
      if (wr_ctrl) begin
        converter_enable <= i_sfr_wdata[`ACC_BIT_ENABLE];
        if (!conversion_done_flag && !conversion_start_busy)
          channel_select_field <= i_sfr_wdata[2:0];
      end
      // Starts while busy or done are simply lost
      if (start) begin
        conversion_start_busy <= 1'b1;
        mc_count              <= 6'h00;
      end else if (abort) begin
        conversion_start_busy <= 1'b0;
        mc_count              <= 6'h00;
      end else if (finish) begin
        conversion_start_busy <= 1'b0;
        conversion_result     <= i_analog_sample;
        mc_count              <= 6'h00;
      end else if (conversion_start_busy && mc_tick) begin
        mc_count <= mc_count + 6'd1;
      end
      // Set wins over a read in the same cycle; never 11
      if (finish)
        conversion_done_flag <= 1'b1;
      else if (rd_res)
        conversion_done_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_sfr_rdata   <= 8'h00;
      o_irq         <= 1'b0;
      o_mux_sel     <= 3'h0;
      o_conv_active <= 1'b0;
    end else begin
      if (i_sfr_addr == `ACC_ADDR_CONTROL)
        o_sfr_rdata <= {2'b00, converter_enable, conversion_done_flag,
                        conversion_start_busy, channel_select_field};
      else if (i_sfr_addr == `ACC_ADDR_RESULT)
        o_sfr_rdata <= conversion_result;
      else
        o_sfr_rdata <= 8'h00;
      o_irq <= conversion_done_flag && i_converter_interrupt_enable;
      o_mux_sel     <= channel_select_field;
      o_conv_active <= conversion_start_busy && converter_enable;
    end
  end

  acc_pin_mux #(.NCH(NCH)) u_pins (
    .i_ref_clk  (i_ref_clk),
    .i_srst     (i_srst),
    .i_enable   (converter_enable),
    .i_chan     (channel_select_field),
    .i_pin_in   (i_pin_in),
    .i_port_out (i_port_out),
    .i_port_oe  (i_port_oe),
    .o_pin_out  (o_pin_out),
    .o_pin_oe   (o_pin_oe),
    .o_port_rd  (o_port_rd)
  );
endmodule // acc_top

// [dv/acc_pins.sv]
`timescale 1ns/1ns
// Far side of the five shared pins: external sources plus port drivers
module acc_pins #(
  parameter [4:0] EXT = 5'h00,
  parameter [7:0] SMP = 8'hA5
) (
  input  wire [4:0] i_out,
  input  wire [4:0] i_oe,
  output wire [4:0] o_lvl,
  output wire [7:0] o_smp
);
  // Undriven pins follow the external sources, held low here
  assign o_lvl = (i_out & i_oe) | (EXT & ~i_oe);
  assign o_smp = SMP;
endmodule // acc_pins

// [dv/acc_top_asserts.sv]
`timescale 1ns/1ns
module acc_top_asserts #(
  parameter NCH = 5
) (
  input wire           i_ref_clk,
  input wire           i_srst,
  input wire [7:0]     i_sfr_addr,
  input wire           i_sfr_rd,
  input wire           i_idle_enter,
  input wire           i_pdown_enter,
  input wire           i_converter_interrupt_enable,
  input wire [7:0]     o_sfr_rdata,
  input wire           o_irq,
  input wire [2:0]     o_mux_sel,
  input wire           o_conv_active,
  input wire [NCH-1:0] o_port_rd
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  reg [9:0] cnt;
  reg       ab;
  // Aborted runs are excused from the length check
  always @(posedge i_ref_clk) begin
    if (i_srst || !o_conv_active) begin
      cnt <= 10'd0;
      ab  <= 1'b0;
    end else begin
      cnt <= cnt + 10'd1;
      ab  <= ab | i_idle_enter | i_pdown_enter;
    end
  end
  property p_len; $fell(o_conv_active) && !ab |-> cnt == 10'd480; endproperty
  a_len: assert property (p_len) else $error("bad length");
  property p_ie; !i_converter_interrupt_enable |=> !o_irq; endproperty
  a_ie: assert property (p_ie) else $error("irq unmasked");
  property p_set;
    $fell(o_conv_active) && !ab && i_converter_interrupt_enable
      |-> ##[0:1] o_irq;
  endproperty
  a_set: assert property (p_set) else $error("no irq");
  property p_clr;
    i_sfr_rd && i_sfr_addr == 8'h84 && o_irq |-> ##[1:2] !o_irq;
  endproperty
  a_clr: assert property (p_clr) else $error("irq stuck");
  property p_abt;
    (i_idle_enter || i_pdown_enter) && o_conv_active
      |-> ##[1:3] !o_conv_active;
  endproperty
  a_abt: assert property (p_abt) else $error("no abort");
  property p_chan; o_conv_active |=> $stable(o_mux_sel); endproperty
  a_chan: assert property (p_chan) else $error("chan moved");
  property p_sel; o_conv_active |-> o_port_rd[o_mux_sel]; endproperty
  a_sel: assert property (p_sel) else $error("sel pin low");
  property p_ctl;
    $past(i_sfr_addr) == 8'hA0
      |-> o_sfr_rdata[7:6] == 2'b00 && o_sfr_rdata[4:3] != 2'b11;
  endproperty
  a_ctl: assert property (p_ctl) else $error("bad ctrl");
endmodule // acc_top_asserts
bind acc_top acc_top_asserts #(.NCH(NCH)) u_chk (.i_ref_clk, .i_srst,
  .i_sfr_addr, .i_sfr_rd, .i_idle_enter, .i_pdown_enter,
  .i_converter_interrupt_enable, .o_sfr_rdata, .o_irq, .o_mux_sel,
  .o_conv_active, .o_port_rd);

// [dv/acc_top_tb.sv]
`timescale 1ns/1ns
module acc_top_tb;
  reg        i_ref_clk, i_srst, i_sfr_wr, i_sfr_rd, i_idle_enter;
  reg        i_pdown_enter, i_converter_interrupt_enable;
  reg  [7:0] i_sfr_addr, i_sfr_wdata, v;
  reg  [4:0] i_port_out, i_port_oe;
  wire [7:0] o_sfr_rdata, i_analog_sample;
  wire [4:0] i_pin_in, o_pin_out, o_pin_oe, o_port_rd;
  wire [2:0] o_mux_sel;
  wire       o_irq, o_conv_active;
  integer    n_errors = 0, total_checks = 0, i;
  acc_top uut (.i_ref_clk, .i_srst, .i_sfr_addr, .i_sfr_wr, .i_sfr_rd,
    .i_sfr_wdata, .o_sfr_rdata, .i_idle_enter, .i_pdown_enter,
    .i_converter_interrupt_enable, .o_irq, .i_analog_sample, .o_mux_sel,
    .o_conv_active, .i_pin_in, .i_port_out, .i_port_oe, .o_pin_out,
    .o_pin_oe, .o_port_rd);
  acc_pins u_pins (.i_out(o_pin_out), .i_oe(o_pin_oe), .o_lvl(i_pin_in),
    .o_smp(i_analog_sample));
  task chk(input string n, input [7:0] e, input [7:0] s);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %0s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge i_ref_clk);
    {i_sfr_addr, i_sfr_wdata, i_sfr_wr} <= {a, d, 1'b1};
    @(posedge i_ref_clk);
    i_sfr_wr <= 1'b0;
  endtask
  task rd(input [7:0] a);
    @(posedge i_ref_clk);
    {i_sfr_addr, i_sfr_rd} <= {a, 1'b1};
    @(posedge i_ref_clk);
    i_sfr_rd <= 1'b0;
    @(posedge i_ref_clk);
    #1 v = o_sfr_rdata;
  endtask
  task pm(input [1:0] m);
    @(posedge i_ref_clk);
    {i_pdown_enter, i_idle_enter} <= m;
    @(posedge i_ref_clk);
    {i_pdown_enter, i_idle_enter} <= 2'b00;
  endtask
  task t_conv;
    wr(8'hA0, 8'h2C);
    wr(8'hA0, 8'h29);
    wr(8'hA0, 8'h21);
    rd(8'hA0); chk("ctrl busy", 8'h2C, v);
    chk("active", 8'h01, {7'd0, o_conv_active});
    repeat (480) @(posedge i_ref_clk);
    rd(8'hA0); chk("ctrl done", 8'h34, v);
    chk("irq", 8'h01, {7'd0, o_irq});
    @(posedge i_ref_clk);
    i_converter_interrupt_enable <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    #1 chk("irq masked", 8'h00, {7'd0, o_irq});
    @(posedge i_ref_clk);
    i_converter_interrupt_enable <= 1'b1;
    wr(8'hA0, 8'h29);
    pm(2'b01);
    rd(8'hA0); chk("ctrl kept", 8'h34, v);
    rd(8'h84); chk("result", 8'hA5, v);
    rd(8'hA0); chk("ctrl clear", 8'h24, v);
    chk("irq off", 8'h00, {7'd0, o_irq});
    $display("test conv finished");
  endtask
  task t_abort;
    for (i = 1; i < 3; i++) begin
      wr(8'hA0, 8'h28 | i);
      repeat (20) @(posedge i_ref_clk);
      chk("rd", 8'h01 << i, {3'd0, o_port_rd});
      pm(i);
      repeat (480) @(posedge i_ref_clk);
      rd(8'hA0); chk("ctrl abort", 8'h20 | i, v);
    end
    $display("test abort finished");
  endtask
  task t_pins;
    for (i = 0; i < 5; i++) begin
      wr(8'hA0, 8'hC0 | i);
      rd(8'hA0); chk("ctrl chan", i, v);
      chk("mux", i, {5'd0, o_mux_sel});
    end
    rd(8'h85); chk("unmapped", 8'h00, v);
    @(posedge i_ref_clk);
    {i_port_out, i_port_oe} <= {5'h0A, 5'h0F};
    repeat (4) @(posedge i_ref_clk);
    #1 chk("pin oe", 8'h0F, {3'd0, o_pin_oe});
    chk("pin out", 8'h0A, {3'd0, o_pin_out});
    chk("pin rd", 8'h0A, {3'd0, o_port_rd});
    $display("test pins finished");
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    repeat (5000) @(posedge i_ref_clk);
    n_errors++;
    wrap_up;
  end
  initial begin
    {i_srst, i_sfr_wr, i_sfr_rd, i_idle_enter, i_pdown_enter} = 5'b10000;
    {i_sfr_addr, i_sfr_wdata, v} = 24'h0;
    // Port drivers stay off while the converter owns the pins
    {i_port_out, i_port_oe} = 10'h0;
    i_converter_interrupt_enable = 1'b1;
    repeat (4) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    t_conv;
    t_abort;
    t_pins;
    wrap_up;
  end
endmodule // acc_top_tb
